// ### logic/sd_irq_pkg.sv
// constants, register map and state codes for the sd host interrupt enable/force block
package sd_irq_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFF_IRQ_FLAGS = 8'h30;
	localparam logic [7:0] OFF_IRQ_FLAG_MASK = 8'h34;
	localparam logic [7:0] OFF_IRQ_OUTPUT_ENABLE = 8'h38;
	localparam logic [7:0] OFF_HOST_CONTROL_TWO = 8'h3c;
	localparam logic [7:0] OFF_IRQ_EVENT_FORCE = 8'h50;

	// reset values
	localparam logic [31:0] RST_IRQ_FLAGS = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_FLAG_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_OUTPUT_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_HOST_CONTROL_TWO = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_EVENT_FORCE = 32'h0000_0000;

	// event bit positions, shared by flags, mask, enable and force
	localparam int EV_CMD_DONE = 0;
	localparam int EV_DATA_DONE = 1;
	localparam int EV_BLOCK_GAP = 2;
	localparam int EV_WRITE_RDY = 4;
	localparam int EV_READ_RDY = 5;
	localparam int EV_CARD = 8;
	localparam int EV_RETUNE = 12;
	localparam int EV_BOOT_ACK = 13;
	localparam int EV_BOOT_END = 14;
	localparam int EV_ERR_SUMMARY = 15;
	localparam int EV_CMD_TIMEOUT = 16;
	localparam int EV_CMD_CRC = 17;
	localparam int EV_CMD_ENDBIT = 18;
	localparam int EV_CMD_INDEX = 19;
	localparam int EV_DATA_TIMEOUT = 20;
	localparam int EV_DATA_CRC = 21;
	localparam int EV_DATA_ENDBIT = 22;
	localparam int EV_AUTO_CMD = 24;

	// implemented event bits; everything else reads zero except the error summary at flag bit 15
	localparam logic [31:0] EVENT_BITS = 32'h017f_7137;
	localparam logic [31:0] ERROR_BITS = 32'h017f_0000;
	// flags that follow their source and cannot be cleared by software
	localparam logic [31:0] LEVEL_BITS = 32'h0000_1100;

	// host_control_two layout
	localparam int CTL_TUNED = 23;
	localparam int CTL_TUNE_ON = 22;
	localparam int CTL_SPEED_LSB = 16;
	localparam int CTL_SPEED_MSB = 18;
	localparam int CTL_AUTO_STOP = 7;
	localparam int CTL_AUTO_INDEX = 4;
	localparam int CTL_AUTO_ENDBIT = 3;
	localparam int CTL_AUTO_CRC = 2;
	localparam int CTL_AUTO_TIMEOUT = 1;
	localparam int CTL_AUTO_NOT_ISSUED = 0;

	typedef enum logic [2:0] {
		SPEED_SDR12 = 3'h0,
		SPEED_SDR25 = 3'h1,
		SPEED_SDR50 = 3'h2,
		SPEED_SDR104 = 3'h3,
		SPEED_DDR50 = 3'h4
	} speed_mode_e;

	typedef enum logic [1:0] {
		TUNE_IDLE = 2'h1,
		TUNE_BUSY = 2'h2
	} tune_state_e;

endpackage

// ### logic/irq_flag_bank.sv
// per-bit interrupt flag storage with mask gating and write-one-to-clear
`timescale 1ns/10ps
module irq_flag_bank (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [31:0] flag_mask,
	input wire logic [31:0] event_set,
	input wire logic [31:0] clear_w1c,
	output logic [31:0] flags
);

	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_bit
			if (!sd_irq_pkg::EVENT_BITS[i]) begin : g_none
				assign flags[i] = 1'b0;
			end else if (sd_irq_pkg::LEVEL_BITS[i]) begin : g_level
				// read-only flags mirror their masked source
				always_ff @(posedge core_clk) begin
					if (!reset_n)
						flags[i] <= sd_irq_pkg::RST_IRQ_FLAGS[i];
					else if (clk_en)
						flags[i] <= event_set[i] & flag_mask[i];
				end
			end else begin : g_sticky
				// a set in the clearing cycle wins so no event is lost
				always_ff @(posedge core_clk) begin
					if (!reset_n)
						flags[i] <= sd_irq_pkg::RST_IRQ_FLAGS[i];
					else if (clk_en)
						flags[i] <= (flags[i] & ~clear_w1c[i]) | (event_set[i] & flag_mask[i]);
				end
			end
		end
	endgenerate

endmodule // irq_flag_bank

// ### logic/sd_host_irq_enable_force.sv
// interrupt enable, interrupt force and second host control register of the sd host
//
// How it works
// - an enable bit at 1 lets its flag drive the cpu interrupt; 0 blocks it
// - enable bits 22, 21, 20 cover data end bit, data crc and data timeout
// - enable bits 19 to 16 cover command index, end bit, crc and timeout
// - enable bit 24 gates the auto command error flag
// - enable bits 14, 13, 12 cover boot end, boot ack and retune request
// - enable bit 8 gates the card interrupt request
// - enable bits 5 and 4 cover read ready and write ready
// - enable bits 2, 1, 0 cover block gap, data done and command done
// - reserved bits are written as zero and read back as zero here
// - control bit 23 selects and shows use of the tuned sampling clock
// - control bit 22 starts tuning, stays 1 while busy, drops when done
// - control bits 18:16 select speed mode sdr12..ddr50; other codes reserved
// - read-only control bit 7 shows an error during auto stop command
// - read-only control bit 4 shows auto command index error
// - read-only control bit 3 shows auto command end bit error
// - read-only control bit 2 shows auto command crc error
// - read-only control bit 1 shows auto command response timeout
// - read-only control bit 0 shows auto command not issued after an error
// - writing 1 to a force bit raises that event as if it really happened
// - force error bits sit at 24 and 22 to 16 like the flags
// - force non-error bits sit at the same positions as the flags
// - flag bit 15 is a read-only summary of enabled error flags
// - the mask decides per bit whether an event may set its flag
`timescale 1ns/10ps
module sd_host_irq_enable_force (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] event_in,
	input wire logic auto_stop_error,
	input wire logic auto_index_error,
	input wire logic auto_endbit_error,
	input wire logic auto_crc_error,
	input wire logic auto_timeout_error,
	input wire logic auto_not_issued,
	input wire logic tuning_done,
	input wire logic tuning_pass,
	output logic tuning_start,
	output logic tuning_in_progress,
	output logic tuned_clk_select,
	output logic [2:0] speed_mode_select,
	output logic cpu_irq_out
);

	// software-visible storage
	logic [31:0] irq_flags;
	logic [31:0] irq_flag_mask;
	logic [31:0] irq_output_enable;
	logic [31:0] irq_event_force;
	logic [5:0] auto_status;
	logic tuned;
	logic [2:0] speed_mode;
	sd_irq_pkg::tune_state_e tune_state;
	sd_irq_pkg::tune_state_e next_tune_state;

	// address decode
	wire hit_flags = reg_addr == sd_irq_pkg::OFF_IRQ_FLAGS;
	wire hit_mask = reg_addr == sd_irq_pkg::OFF_IRQ_FLAG_MASK;
	wire hit_enable = reg_addr == sd_irq_pkg::OFF_IRQ_OUTPUT_ENABLE;
	wire hit_ctl = reg_addr == sd_irq_pkg::OFF_HOST_CONTROL_TWO;
	wire hit_force = reg_addr == sd_irq_pkg::OFF_IRQ_EVENT_FORCE;

	wire wr_flags = reg_wr & hit_flags;
	wire wr_mask = reg_wr & hit_mask;
	wire wr_enable = reg_wr & hit_enable;
	wire wr_ctl = reg_wr & hit_ctl;
	wire wr_force = reg_wr & hit_force;

	// reserved positions never store anything, whatever software writes
	wire [31:0] wdata_events = reg_wdata & sd_irq_pkg::EVENT_BITS;

	// a force write is a one-cycle event pulse into the flag logic
	wire [31:0] force_pulse = wr_force ? wdata_events : 32'h0000_0000;
	wire [31:0] event_set = (event_in & sd_irq_pkg::EVENT_BITS) | force_pulse;

	// software clears sticky flags by writing 1; level flags ignore it
	wire [31:0] flag_clear = wr_flags ? (wdata_events & ~sd_irq_pkg::LEVEL_BITS) : 32'h0000_0000;

	irq_flag_bank u_flags (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.flag_mask(irq_flag_mask),
		.event_set(event_set),
		.clear_w1c(flag_clear),
		.flags(irq_flags)
	);

	// gated flags: one term per event position
	wire [31:0] gated_flags = irq_flags & irq_output_enable;

	// summary is derived, so it can never be stale or cleared on its own
	wire err_summary = |(gated_flags & sd_irq_pkg::ERROR_BITS);

	wire [31:0] flags_view = irq_flags | ({31'h0000_0000, err_summary} << sd_irq_pkg::EV_ERR_SUMMARY);

	wire next_irq = |gated_flags;

	// mask register
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			irq_flag_mask <= sd_irq_pkg::RST_IRQ_FLAG_MASK;
		else if (clk_en && wr_mask)
			irq_flag_mask <= wdata_events;
	end

	// enable register
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			irq_output_enable <= sd_irq_pkg::RST_IRQ_OUTPUT_ENABLE;
		else if (clk_en && wr_enable)
			irq_output_enable <= wdata_events;
	end

	// force register keeps the last written pattern for read-back only
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			irq_event_force <= sd_irq_pkg::RST_IRQ_EVENT_FORCE;
		else if (clk_en && wr_force)
			irq_event_force <= wdata_events;
	end

	// interrupt output, registered so it is glitch free toward the cpu
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			cpu_irq_out <= 1'b0;
		else if (clk_en)
			cpu_irq_out <= next_irq;
	end

	// host_control_two writable fields
	wire ctl_speed_wr = wr_ctl;
	wire [2:0] wdata_speed = reg_wdata[sd_irq_pkg::CTL_SPEED_MSB:sd_irq_pkg::CTL_SPEED_LSB];
	wire tune_request = wr_ctl & reg_wdata[sd_irq_pkg::CTL_TUNE_ON];

	// reserved speed codes are stored as written; the card engine must not rely on them
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			speed_mode <= sd_irq_pkg::RST_HOST_CONTROL_TWO[sd_irq_pkg::CTL_SPEED_MSB:sd_irq_pkg::CTL_SPEED_LSB];
		else if (clk_en && ctl_speed_wr)
			speed_mode <= wdata_speed;
	end

	// tuning sequencer
	always_comb begin
		next_tune_state = tune_state;
		unique case (tune_state)
			sd_irq_pkg::TUNE_IDLE: begin
				if (tune_request)
					next_tune_state = sd_irq_pkg::TUNE_BUSY;
			end
			sd_irq_pkg::TUNE_BUSY: begin
				// software cannot abort by writing 0; only completion ends it
				if (tuning_done)
					next_tune_state = sd_irq_pkg::TUNE_IDLE;
			end
			default: next_tune_state = sd_irq_pkg::TUNE_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n)
			tune_state <= sd_irq_pkg::TUNE_IDLE;
		else if (clk_en)
			tune_state <= next_tune_state;
	end

	wire tune_busy = tune_state == sd_irq_pkg::TUNE_BUSY;
	wire tune_finish = tune_busy & tuning_done;

	// start pulse to the delay-line tuner, one cycle on leaving idle
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			tuning_start <= 1'b0;
		else if (clk_en)
			tuning_start <= (tune_state == sd_irq_pkg::TUNE_IDLE) & tune_request;
	end

	// tuned select: software may set or clear it; a passing tune sets it and wins
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			tuned <= sd_irq_pkg::RST_HOST_CONTROL_TWO[sd_irq_pkg::CTL_TUNED];
		else if (clk_en) begin
			if (tune_finish && tuning_pass)
				tuned <= 1'b1;
			else if (tune_finish)
				tuned <= 1'b0;
			else if (wr_ctl)
				tuned <= reg_wdata[sd_irq_pkg::CTL_TUNED];
		end
	end

	// auto command status mirrors the command engine each cycle
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			auto_status <= 6'h00;
		else if (clk_en)
			auto_status <= {auto_stop_error, auto_index_error, auto_endbit_error,
				auto_crc_error, auto_timeout_error, auto_not_issued};
	end

	wire [31:0] ctl_view;
	assign ctl_view[31:24] = 8'h00;
	assign ctl_view[sd_irq_pkg::CTL_TUNED] = tuned;
	assign ctl_view[sd_irq_pkg::CTL_TUNE_ON] = tune_busy;
	assign ctl_view[21:19] = 3'h0;
	assign ctl_view[sd_irq_pkg::CTL_SPEED_MSB:sd_irq_pkg::CTL_SPEED_LSB] = speed_mode;
	assign ctl_view[15:8] = 8'h00;
	assign ctl_view[sd_irq_pkg::CTL_AUTO_STOP] = auto_status[5];
	assign ctl_view[6:5] = 2'h0;
	assign ctl_view[sd_irq_pkg::CTL_AUTO_INDEX] = auto_status[4];
	assign ctl_view[sd_irq_pkg::CTL_AUTO_ENDBIT] = auto_status[3];
	assign ctl_view[sd_irq_pkg::CTL_AUTO_CRC] = auto_status[2];
	assign ctl_view[sd_irq_pkg::CTL_AUTO_TIMEOUT] = auto_status[1];
	assign ctl_view[sd_irq_pkg::CTL_AUTO_NOT_ISSUED] = auto_status[0];

	// read mux; unmapped addresses answer zero
	wire [31:0] read_mux =
		hit_flags ? flags_view :
		hit_mask ? irq_flag_mask :
		hit_enable ? irq_output_enable :
		hit_ctl ? ctl_view :
		hit_force ? irq_event_force :
		32'h0000_0000;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			reg_rdata <= 32'h0000_0000;
		else if (clk_en)
			reg_rdata <= reg_rd ? read_mux : 32'h0000_0000;
	end

	// outputs toward the card engine
	assign tuning_in_progress = tune_busy;
	assign tuned_clk_select = tuned;
	assign speed_mode_select = speed_mode;

endmodule // sd_host_irq_enable_force

// ### verif/sd_irq_chk_sva.sv
// port-level assertions for the sd host interrupt enable/force block
`timescale 1ns/10ps
module sd_irq_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic tuning_done,
	input wire logic tuning_pass,
	input wire logic tuning_start,
	input wire logic tuning_in_progress,
	input wire logic tuned_clk_select,
	input wire logic [2:0] speed_mode_select,
	input wire logic cpu_irq_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire wr_ctl = clk_en && reg_wr && reg_addr == 8'h3c;
	wire rd_unmapped = clk_en && reg_rd && !(reg_addr inside {8'h30, 8'h34, 8'h38, 8'h3c, 8'h50});
	sequence s_tune_req;
		wr_ctl && reg_wdata[22] && !tuning_in_progress;
	endsequence
	sequence s_tune_end;
		clk_en && tuning_in_progress && tuning_done;
	endsequence
	AST_UNMAPPED_ZERO: assert property (rd_unmapped |=> reg_rdata == 32'h0)
		else $error("unmapped read returned nonzero");
	AST_ENABLE_RSV: assert property (clk_en && reg_rd && reg_addr == 8'h38 |=> (reg_rdata & 32'hfe80_8ec8) == 32'h0)
		else $error("reserved enable bits read nonzero");
	AST_TUNE_START: assert property (s_tune_req |=> tuning_start && tuning_in_progress)
		else $error("tuning did not start");
	AST_START_PULSE: assert property (clk_en && tuning_start |=> !tuning_start)
		else $error("tuning start longer than one cycle");
	AST_TUNE_HOLD: assert property (tuning_in_progress && !tuning_done |=> tuning_in_progress)
		else $error("tuning dropped before done");
	AST_TUNE_END: assert property (s_tune_end |=> !tuning_in_progress && tuned_clk_select == $past(tuning_pass))
		else $error("tuning end handled wrongly");
	AST_SPEED_WR: assert property (wr_ctl |=> speed_mode_select == $past(reg_wdata[18:16]))
		else $error("speed mode not taken from write");
	AST_IRQ_OFF: assert property (clk_en && reg_wr && reg_addr == 8'h38 && reg_wdata == 32'h0 ##1 clk_en
		|=> !cpu_irq_out)
		else $error("interrupt with all enables clear");
endmodule // sd_irq_chk

bind sd_host_irq_enable_force sd_irq_chk chk_u (.core_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .tuning_done, .tuning_pass, .tuning_start, .tuning_in_progress, .tuned_clk_select,
	.speed_mode_select, .cpu_irq_out);

// ### verif/sd_host_irq_enable_force_tb.sv
// self-checking testbench for the sd host interrupt enable/force block
`timescale 1ns/10ps
module sd_host_irq_enable_force_tb;
	localparam logic [31:0] EVB = sd_irq_pkg::EVENT_BITS;
	localparam logic [31:0] LVB = sd_irq_pkg::LEVEL_BITS;
	localparam logic [31:0] ERB = sd_irq_pkg::ERROR_BITS;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic tuning_done = 1'b0;
	logic tuning_pass = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] event_in = 32'h0;
	logic [31:0] rnd;
	logic [31:0] reg_rdata;
	logic [5:0] auto_err = 6'h00;
	logic tuning_start, tuning_in_progress, tuned_clk_select, cpu_irq_out;
	logic [2:0] speed_mode_select;
	logic [31:0] exp_q[$];
	int err_count = 0;
	int n_compared = 0;
	int seed = 60;

	always #4 core_clk = ~core_clk;

	sd_host_irq_enable_force dut_u (.core_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .event_in, .auto_stop_error(auto_err[5]), .auto_index_error(auto_err[4]),
		.auto_endbit_error(auto_err[3]), .auto_crc_error(auto_err[2]), .auto_timeout_error(auto_err[1]),
		.auto_not_issued(auto_err[0]), .tuning_done, .tuning_pass, .tuning_start, .tuning_in_progress,
		.tuned_clk_select, .speed_mode_select, .cpu_irq_out);

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// expectation queued before the strobe so the monitor always finds it
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task test_done;
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d)
			chk("read data", exp_q.pop_front(), reg_rdata);
		rd_d <= reg_rd;
	end

	initial begin
		#100000;
		err_count++;
		test_done;
	end

	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(8'h38, 32'h0);
		rd(8'h3c, 32'h0);
		rd(8'h50, 32'h0);
		rd(8'h44, 32'h0);
		rnd = $random(seed);
		wr(8'h38, rnd);
		rd(8'h38, rnd & EVB);
		rnd = $random(seed);
		wr(8'h50, rnd);
		rd(8'h50, rnd & EVB);
		rd(8'h30, 32'h0);
		wr(8'h34, EVB);
		for (int b = 0; b < 25; b++) if (EVB[b]) begin
			wr(8'h38, 32'h0);
			if (LVB[b])
				event_in[b] <= 1'b1;
			else
				wr(8'h50, 32'h1 << b);
			tick(3);
			chk("irq gated", 32'h0, cpu_irq_out);
			wr(8'h38, 32'h1 << b);
			tick(3);
			chk("irq raised", 32'h1, cpu_irq_out);
			rd(8'h30, (32'h1 << b) | (ERB[b] ? 32'h8000 : 32'h0));
			if (LVB[b])
				event_in[b] <= 1'b0;
			else
				wr(8'h30, 32'h1 << b);
			tick(3);
			chk("irq cleared", 32'h0, cpu_irq_out);
		end
		for (int m = 0; m < 5; m++) begin
			wr(8'h3c, m << 16);
			#1;
			chk("speed mode", m, speed_mode_select);
		end
		wr(8'h3c, 32'h0040_0000);
		#1;
		chk("tune start", 32'h1, tuning_start);
		rd(8'h3c, 32'h0040_0000);
		// a zero written while busy must not abort the tuner
		wr(8'h3c, 32'h0);
		#1;
		chk("tune busy", 32'h1, tuning_in_progress);
		@(posedge core_clk);
		tuning_done <= 1'b1;
		tuning_pass <= 1'b1;
		@(posedge core_clk);
		tuning_done <= 1'b0;
		#1;
		chk("tune busy", 32'h0, tuning_in_progress);
		chk("tuned clock", 32'h1, tuned_clk_select);
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			auto_err <= 6'h01 << i;
			tick(2);
			rd(8'h3c, 32'h0080_0000 | (32'h1 << (i == 5 ? 7 : i)));
		end
		// a failing tune must drop the tuned select even though software set it
		tuning_pass <= 1'b0;
		wr(8'h3c, 32'h00c0_0000);
		#1;
		chk("tune start", 32'h1, tuning_start);
		@(posedge core_clk);
		tuning_done <= 1'b1;
		@(posedge core_clk);
		tuning_done <= 1'b0;
		#1;
		chk("tune busy", 32'h0, tuning_in_progress);
		chk("tuned clock", 32'h0, tuned_clk_select);
		rd(8'h3c, 32'h0000_0080);
		// a write while the clock enable is low must not land
		clk_en <= 1'b0;
		wr(8'h38, 32'h0000_0001);
		clk_en <= 1'b1;
		rd(8'h38, 32'h0100_0000);
		tick(2);
		test_done;
	end
endmodule // sd_host_irq_enable_force_tb
